// ### dvl_consts.svh
`ifndef DVL_CONSTS_SVH
`define DVL_CONSTS_SVH

`define DVL_CHANNELS    12
`define DVL_WORD_W      10
`define DVL_IDX_W       4
`define DVL_PHASE_W     3
`define DVL_LAST_PHASE  3'h5
`define DVL_FIRST_SLOT  3'h0
`define DVL_LAST_CHAN   4'hB
`define DVL_INV_DELAY   8
`define DVL_FIFO_DEPTH  8

`endif

// ### dvl_pkg.sv
`include "dvl_consts.svh"

package dvl_pkg;

	typedef logic [`DVL_WORD_W-1:0] dvl_word_t;

	typedef struct packed {
		dvl_word_t [`DVL_CHANNELS-1:0] ch;
	} dvl_line_t;

endpackage

// ### dvl_loader.sv
`timescale 1ns/1ps
`include "dvl_consts.svh"

module dvl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `DVL_FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              do_push = in_valid && in_ready;
	wire              do_pop  = out_valid && out_ready;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= ptr_inc(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= ptr_inc(rd_ptr);
			end
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule

// Contract
// - A sequence start launches a six-clock load that stores twelve successive words, one per channel.
// - Words are captured on every rising and every falling clock edge while a load runs.
// - A load begins at a rising edge only when sequence_start was high at the rising edge before it.
// - One shared 10-bit data bus feeds all twelve channels, each holding a full 10-bit code.
// - With load_direction low loading runs channel 0 up to 11, with it high from 11 down to 0.
// - Loaded data reaches all twelve outputs at once on the rising edge after output_transfer was seen high.
// - A change of polarity_invert reaches the video_invert output nine clocks later.
module dvl_loader #(
	parameter int CHANNELS   = `DVL_CHANNELS,
	parameter int INV_DELAY  = `DVL_INV_DELAY,
	parameter int FIFO_DEPTH = `DVL_FIFO_DEPTH
) (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire dvl_pkg::dvl_word_t video_data,
	input  wire logic              sequence_start,
	input  wire logic              load_direction,
	input  wire logic              output_transfer,
	input  wire logic              polarity_invert,
	output dvl_pkg::dvl_line_t     video_code,
	output logic                   video_invert,
	output logic                   load_ready,
	output logic                   line_lost
);
	dvl_pkg::dvl_word_t               hold [CHANNELS];
	dvl_pkg::dvl_word_t               next_hold [CHANNELS];
	dvl_pkg::dvl_word_t               fall_word;
	logic                             start_q;
	logic                             xfr_q;
	logic                             active;
	logic                             dir;
	logic [`DVL_PHASE_W-1:0]          phase;
	logic                             pend;
	logic                             pend_last;
	logic [`DVL_IDX_W-1:0]            pend_idx;
	logic                             inv_pipe [INV_DELAY];
	logic                             inv_prev [INV_DELAY];
	dvl_pkg::dvl_line_t               push_line;
	dvl_pkg::dvl_line_t               pop_line;
	logic                             fifo_in_ready;
	logic                             fifo_out_valid;

	function automatic logic [`DVL_IDX_W-1:0] chan_index(input logic [`DVL_IDX_W-1:0] n, input logic d);
		chan_index = d ? `DVL_IDX_W'(`DVL_LAST_CHAN - n) : n;
	endfunction

	wire                     write_en  = start_q || active;
	wire                     cur_dir   = start_q ? load_direction : dir;
	wire [`DVL_PHASE_W-1:0]  cur_slot  = start_q ? `DVL_FIRST_SLOT : phase;
	wire [`DVL_IDX_W-1:0]    rise_num  = {cur_slot, 1'b0};
	wire [`DVL_IDX_W-1:0]    rise_idx  = chan_index(rise_num, cur_dir);
	wire [`DVL_IDX_W-1:0]    fall_idx  = chan_index(rise_num | `DVL_IDX_W'(1), cur_dir);
	wire                     slot_last = (cur_slot == `DVL_LAST_PHASE);
	wire                     push      = pend && pend_last;
	wire                     pop       = xfr_q && fifo_out_valid;

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			assign next_hold[gi]  = (pend && pend_idx == `DVL_IDX_W'(gi)) ? fall_word : hold[gi];
			assign push_line.ch[gi] = next_hold[gi];
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					hold[gi] <= '0;
				end else if (write_en && rise_idx == `DVL_IDX_W'(gi)) begin
					hold[gi] <= video_data;
				end else begin
					hold[gi] <= next_hold[gi];
				end
			end
		end
	endgenerate

	always_ff @(negedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fall_word <= '0;
		end else begin
			fall_word <= video_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			start_q <= 1'b0;
			xfr_q   <= 1'b0;
		end else begin
			start_q <= sequence_start;
			xfr_q   <= output_transfer;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			active <= 1'b0;
			dir    <= 1'b0;
			phase  <= '0;
		end else begin
			active <= write_en && !slot_last;
			dir    <= cur_dir;
			phase  <= cur_slot + `DVL_PHASE_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend      <= 1'b0;
			pend_last <= 1'b0;
			pend_idx  <= '0;
		end else begin
			pend      <= write_en;
			pend_last <= write_en && slot_last;
			pend_idx  <= fall_idx;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			video_code <= '0;
		end else if (pop) begin
			video_code <= pop_line;
		end
	end

	genvar si;
	generate
		for (si = 0; si < INV_DELAY; si++) begin : g_inv
			if (si == 0) begin : g_head
				assign inv_prev[si] = polarity_invert;
			end else begin : g_tail
				assign inv_prev[si] = inv_pipe[si-1];
			end
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					inv_pipe[si] <= 1'b0;
				end else begin
					inv_pipe[si] <= inv_prev[si];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			video_invert <= 1'b0;
		end else begin
			video_invert <= inv_pipe[INV_DELAY-1];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			load_ready <= 1'b0;
			line_lost  <= 1'b0;
		end else begin
			load_ready <= fifo_in_ready;
			line_lost  <= push && !fifo_in_ready;
		end
	end

	dvl_fifo #(
		.WIDTH ($bits(dvl_pkg::dvl_line_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_line),
		.out_valid (fifo_out_valid),
		.out_ready (xfr_q),
		.out_data  (pop_line)
	);
endmodule

// ### dvl_loader_checker.sv
`timescale 1ns/1ps
module dvl_loader_checker (
	input wire logic               ref_clk,
	input wire logic               rstn,
	input wire logic               sequence_start,
	input wire logic               output_transfer,
	input wire logic               polarity_invert,
	input wire dvl_pkg::dvl_line_t video_code,
	input wire logic               video_invert,
	input wire logic               load_ready,
	input wire logic               line_lost
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_inv_delay: assert property ($changed(polarity_invert) |->
		##9 video_invert == $past(polarity_invert, 9)) else $error("invert late");
	a_inv_cause: assert property ($changed(video_invert) |->
		$past(polarity_invert, 9) != $past(polarity_invert, 10)) else $error("invert moved");
	a_code_hold: assert property ($changed(video_code) |-> $past(output_transfer, 2)) else $error("code moved");
	a_lost_cause: assert property (line_lost |->
		$past(sequence_start, 8) && !$past(sequence_start, 7)) else $error("lost timing");
	a_lost_gap: assert property (line_lost |=> !line_lost [*5]) else $error("lost twice");
	a_ready_fall: assert property ($fell(load_ready) |-> $past(sequence_start, 9)) else $error("ready fell");
	a_ready_rise: assert property ($rose(load_ready) |->
		!$past(rstn, 2) || $past(output_transfer, 3)) else $error("ready rose");
	a_lost_full: assert property (line_lost |-> !load_ready) else $error("lost with room");
	c_lost: cover property (line_lost);
	c_xfer: cover property (output_transfer ##2 $changed(video_code));
	c_inv: cover property ($rose(video_invert));
endmodule
bind dvl_loader dvl_loader_checker chk (
	.ref_clk         (ref_clk),
	.rstn            (rstn),
	.sequence_start  (sequence_start),
	.output_transfer (output_transfer),
	.polarity_invert (polarity_invert),
	.video_code      (video_code),
	.video_invert    (video_invert),
	.load_ready      (load_ready),
	.line_lost       (line_lost)
);

// ### dvl_source.sv
`timescale 1ns/1ps
module dvl_source (
	input wire logic               ref_clk,
	input wire logic               go,
	input wire dvl_pkg::dvl_word_t base,
	output logic                   sequence_start,
	output dvl_pkg::dvl_word_t     video_data
);
	initial begin
		sequence_start = 0;
		video_data = '0;
		forever begin
			@(posedge ref_clk);
			#1;
			if (go) begin
				sequence_start = 1;
				@(posedge ref_clk);
				#1 sequence_start = 0;
				video_data = base;
				@(posedge ref_clk);
				for (int i = 1; i < 12; i++) begin
					#1 video_data = base + 10'(i);
					@(ref_clk);
				end
			end else video_data = ~video_data;
		end
	end
endmodule

// ### dvl_loader_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t bad value", $time); end end
module dvl_loader_tb;
	logic ref_clk = 0, rstn = 0, go = 0, load_direction = 0, output_transfer = 0, polarity_invert = 0;
	logic sequence_start, video_invert, load_ready, line_lost;
	dvl_pkg::dvl_word_t base = '0, video_data;
	dvl_pkg::dvl_line_t video_code;
	int n_errors = 0, checked = 0, lost = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) lost += int'(line_lost);
	dvl_source SRC (.ref_clk(ref_clk), .go(go), .base(base), .sequence_start(sequence_start), .video_data(video_data));
	dvl_loader DUT (.ref_clk(ref_clk), .rstn(rstn), .video_data(video_data), .sequence_start(sequence_start),
		.load_direction(load_direction), .output_transfer(output_transfer), .polarity_invert(polarity_invert),
		.video_code(video_code), .video_invert(video_invert), .load_ready(load_ready), .line_lost(line_lost));
	task cyc(int n); repeat (n) @(negedge ref_clk); endtask
	task load(logic d, int b);
		load_direction = d;
		base = 10'(b);
		go = 1;
		cyc(1);
		go = 0;
		cyc(9);
	endtask
	task xfer; output_transfer = 1; cyc(1); output_transfer = 0; cyc(1); endtask
	task t_dir(logic d, int b);
		load(d, b);
		xfer;
		for (int i = 0; i < 12; i++) `CHK(video_code.ch[d ? 11 - i : i], 10'(b + i))
	endtask
	task t_inv;
		polarity_invert = 1;
		cyc(8);
		`CHK(video_invert, 1'b0)
		cyc(1);
		`CHK(video_invert, 1'b1)
		polarity_invert = 0;
		cyc(8);
		`CHK(video_invert, 1'b1)
		cyc(1);
		`CHK(video_invert, 1'b0)
	endtask
	task t_fifo;
		for (int k = 0; k < 9; k++) load(0, k * 64);
		`CHK(load_ready, 1'b0)
		`CHK(lost, 1)
		`CHK(line_lost, 1'b0)
		for (int k = 0; k < 8; k++) begin xfer; `CHK(video_code.ch[1], 10'(k * 64 + 1)) end
		xfer;
		`CHK(video_code.ch[1], 10'h1C1)
	endtask
	task conclude;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin cyc(3000); n_errors++; conclude; end
	initial begin
		cyc(8);
		rstn = 1;
		cyc(2);
		t_dir(0, 10'h100);
		t_dir(1, 10'h200);
		t_inv;
		t_fifo;
		conclude;
	end
endmodule
